/* bdc_pkg.sv */
package bdc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map: register index, byte address is four times the index
    localparam int             ADDR_W          = 12;
    localparam logic [7:0]     IDX_CTRL_MAIN   = 8'hA3;
    localparam logic [7:0]     IDX_CTRL_LP     = 8'hAB;
    localparam logic [7:0]     IDX_IRQ_STATUS  = 8'hB0;
    localparam logic [7:0]     IDX_IRQ_ENABLE  = 8'hB1;
    localparam logic [7:0]     IDX_IRQ_CLEAR   = 8'hB2;
    localparam logic [7:0]     IDX_UNLOCK      = 8'hB3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int             MAIN_EN_BIT     = 7;
    localparam int             MAIN_THR_HI     = 6;
    localparam int             MAIN_THR_LO     = 4;
    localparam int             MAIN_EVT_BIT    = 3;
    localparam int             MAIN_RSTEN_BIT  = 2;
    localparam int             MAIN_RFLAG_BIT  = 1;
    localparam int             MAIN_STAT_BIT   = 0;
    localparam int             LP_MODE_HI      = 2;
    localparam int             LP_MODE_LO      = 1;
    localparam int             LP_FLT_BIT      = 0;
    localparam int             IRQ_FALL_BIT    = 0;
    localparam int             IRQ_RISE_BIT    = 1;

    ////////////////////////////////////////////////////////////////////////////
    // Codes and reset values
    localparam logic [1:0]     THR_2V2         = 2'h3;
    localparam logic [1:0]     THR_2V7         = 2'h2;
    localparam logic [1:0]     THR_3V7         = 2'h1;
    localparam logic [1:0]     THR_4V4         = 2'h0;
    localparam logic [1:0]     MODE_CONTINUOUS = 2'h0;
    localparam logic [1:0]     LP_MODE_RESET   = 2'h0;
    localparam logic           FLT_RESET       = 1'h0;
    localparam logic [1:0]     IRQ_RESET       = 2'h0;
    localparam logic [7:0]     UNLOCK_KEY1     = 8'hAA;
    localparam logic [7:0]     UNLOCK_KEY2     = 8'h55;
    localparam logic [2:0]     UNLOCK_WINDOW   = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Timing: periods in microseconds, counted in slow oscillator ticks
    localparam int             SLOW_OSC_KHZ    = 10;
    localparam int             LP1_PERIOD_US   = 1600;
    localparam int             LP2_PERIOD_US   = 6400;
    localparam int             LP3_PERIOD_US   = 25600;
    localparam int             LP1_TICKS       = LP1_PERIOD_US * SLOW_OSC_KHZ / 1000;
    localparam int             LP2_TICKS       = LP2_PERIOD_US * SLOW_OSC_KHZ / 1000;
    localparam int             LP3_TICKS       = LP3_PERIOD_US * SLOW_OSC_KHZ / 1000;
    localparam int             FAST_FILT_CYC   = 32;
    localparam int             SLOW_FILT_TICKS = 2;
    localparam int             BLANK_TICKS     = 3;

    typedef enum logic [2:0] {
        FILT_NONE = 3'b001,
        FILT_FAST = 3'b010,
        FILT_SLOW = 3'b100
    } bdc_filt_e;

endpackage : bdc_pkg

/* bdc_brownout_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - Detector enable bit 7; detector output ignored 2-3 slow ticks after enabling.
// - Threshold bits 6:4: 11=2.2V, 10=2.7V, 01=3.7V, 00=4.4V.
// - Event flag bit 3 set on every threshold crossing, either direction.
// - Interrupt only while event flag, an enabled drop or rise status bit and global enable all set.
// - Reset enable bit 2: drop below threshold resets device when set.
// - Drop reset flag bit 1 set by a brown-out reset; software clears.
// - Status bit 0 shows supply below threshold, zero when detector disabled.
// - Enable, threshold and reset enable load from config byte after reset.
// - Event flag resets to 1 only if enabled, no reset-enable, supply low.
// - Both control registers change only through the timed write unlock.
// - Mode bits 2:1: continuous, or sampling every 1.6, 6.4, 25.6 ms.
// - Filter on, fast clock, continuous: change must persist 32 system clocks.
// - Otherwise with filter on, change must persist 2 slow oscillator ticks.
// - In power-down the output is always filtered by 2 slow ticks.
// - Filter bit 0 enables noise filter; zero after power-on reset.
// - Periodic modes detect pulses of 16/64/256 ticks, plus 2 filtered.
// - Continuous filtered: 32 system clocks, or 2 ticks in power-down/slow clock.
module bdc_brownout_ctrl #(
    parameter int LP1_PERIOD = bdc_pkg::LP1_TICKS,
    parameter int LP2_PERIOD = bdc_pkg::LP2_TICKS,
    parameter int LP3_PERIOD = bdc_pkg::LP3_TICKS
) (
    input  wire logic                        i_core_clk,
    input  wire logic                        i_reset,
    input  wire logic                        i_clk_en,
    input  wire logic                        i_psel,
    input  wire logic                        i_penable,
    input  wire logic                        i_pwrite,
    input  wire logic [bdc_pkg::ADDR_W-1:0]  i_paddr,
    input  wire logic [31:0]                 i_pwdata,
    output logic      [31:0]                 o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire logic [7:0]                  i_nonvolatile_config_byte,
    input  wire logic                        i_power_on_reset,
    input  wire logic                        i_supply_below,
    input  wire logic                        i_slow_internal_osc,
    input  wire logic                        i_slow_osc_is_sysclk,
    input  wire logic                        i_power_down,
    input  wire logic                        i_global_irq_enable,
    output logic                             o_detector_power,
    output logic      [1:0]                  o_trip_select,
    output logic                             o_reset_req,
    output logic                             o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic logic reg_hit(input logic [bdc_pkg::ADDR_W-1:0] addr,
                                     input logic [7:0]                 idx);
        reg_hit = (addr == {2'h0, idx, 2'h0});
    endfunction : reg_hit

    function automatic logic [7:0] period_m1(input logic [1:0] mode);
        case (mode)
            2'h1:    period_m1 = 8'(LP1_PERIOD - 1);
            2'h2:    period_m1 = 8'(LP2_PERIOD - 1);
            default: period_m1 = 8'(LP3_PERIOD - 1);
        endcase
    endfunction : period_m1

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    logic       detector_enable_ff;
    logic [2:0] threshold_select_ff;
    logic       event_flag_ff;
    logic       reset_on_drop_enable_ff;
    logic       drop_reset_flag_ff;
    logic [1:0] periodic_sample_mode_ff;
    logic       noise_filter_enable_ff;
    logic [1:0] irq_status_ff;
    logic [1:0] irq_enable_ff;
    logic       unlock_stage_ff;
    logic [2:0] unlock_cnt_ff;
    logic       accepted_ff;

    logic       pready_ff;
    logic [31:0] prdata_ff;
    logic       pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for comparator and slow oscillator

    logic below_s1_ff, below_s2_ff;
    logic osc_s1_ff, osc_s2_ff, osc_s3_ff;
    logic slow_tick;

    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            below_s1_ff <= i_supply_below;
            below_s2_ff <= below_s1_ff;
            osc_s1_ff   <= i_slow_internal_osc;
            osc_s2_ff   <= osc_s1_ff;
            osc_s3_ff   <= osc_s2_ff;
        end
    end

    assign slow_tick = osc_s2_ff & ~osc_s3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus access

    logic apb_wr;
    logic hit_main, hit_lp, hit_st, hit_en, hit_clr, hit_unl, hit_any;
    logic ta_open;
    logic wr_main, wr_lp;

    assign hit_main = reg_hit(i_paddr, bdc_pkg::IDX_CTRL_MAIN);
    assign hit_lp   = reg_hit(i_paddr, bdc_pkg::IDX_CTRL_LP);
    assign hit_st   = reg_hit(i_paddr, bdc_pkg::IDX_IRQ_STATUS);
    assign hit_en   = reg_hit(i_paddr, bdc_pkg::IDX_IRQ_ENABLE);
    assign hit_clr  = reg_hit(i_paddr, bdc_pkg::IDX_IRQ_CLEAR);
    assign hit_unl  = reg_hit(i_paddr, bdc_pkg::IDX_UNLOCK);
    assign hit_any  = hit_main | hit_lp | hit_st | hit_en | hit_clr | hit_unl;
    assign apb_wr   = i_clk_en & i_psel & i_penable & pready_ff & i_pwrite;
    assign ta_open  = (unlock_cnt_ff != 3'h0);
    assign wr_main  = apb_wr & hit_main & ta_open;
    assign wr_lp    = apb_wr & hit_lp & ta_open;

    // No wait state: read data and ready are registered in the setup cycle, so both leave flip-flops
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (i_clk_en) begin
            pready_ff  <= i_psel & ~i_penable;
            pslverr_ff <= i_psel & ~i_penable & ~hit_any;
            if (i_psel & ~i_penable) begin
                prdata_ff <= 32'h0000_0000;
                if (hit_main) begin
                    prdata_ff[7:0] <= {detector_enable_ff, threshold_select_ff,
                                       event_flag_ff, reset_on_drop_enable_ff,
                                       drop_reset_flag_ff, accepted_ff};
                end else if (hit_lp) begin
                    prdata_ff[2:0] <= {periodic_sample_mode_ff, noise_filter_enable_ff};
                end else if (hit_st) begin
                    prdata_ff[1:0] <= irq_status_ff;
                end else if (hit_en) begin
                    prdata_ff[1:0] <= irq_enable_ff;
                end
            end
        end
    end

    // Timed write unlock: two keys back to back open a short window
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            unlock_stage_ff <= 1'b0;
            unlock_cnt_ff   <= 3'h0;
        end else if (i_clk_en) begin
            if (apb_wr & hit_unl) begin
                unlock_stage_ff <= (i_pwdata[7:0] == bdc_pkg::UNLOCK_KEY1);
                if (unlock_stage_ff & (i_pwdata[7:0] == bdc_pkg::UNLOCK_KEY2)) begin
                    unlock_cnt_ff <= bdc_pkg::UNLOCK_WINDOW;
                end
            end else if (wr_main | wr_lp) begin
                unlock_cnt_ff <= 3'h0;
            end else if (ta_open) begin
                unlock_cnt_ff <= unlock_cnt_ff - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Periodic sampling and enable blanking

    logic       enable_prev_ff;
    logic [1:0] blank_cnt_ff;
    logic [7:0] period_cnt_ff;
    logic       continuous;
    logic       sample_now;
    logic       raw_ff;

    assign continuous = (periodic_sample_mode_ff == bdc_pkg::MODE_CONTINUOUS);
    assign sample_now = continuous |
                        (slow_tick & (period_cnt_ff == period_m1(periodic_sample_mode_ff)));

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            enable_prev_ff   <= 1'b0;
            blank_cnt_ff     <= 2'h0;
            period_cnt_ff    <= 8'h00;
            raw_ff           <= 1'b0;
            o_detector_power <= 1'b0;
        end else if (i_clk_en) begin
            enable_prev_ff <= detector_enable_ff;
            if (detector_enable_ff & ~enable_prev_ff) begin
                blank_cnt_ff <= 2'(bdc_pkg::BLANK_TICKS);
            end else if (slow_tick & (blank_cnt_ff != 2'h0)) begin
                blank_cnt_ff <= blank_cnt_ff - 2'h1;
            end
            if (continuous | ~detector_enable_ff) begin
                period_cnt_ff <= 8'h00;
            end else if (slow_tick) begin
                period_cnt_ff <= (period_cnt_ff == period_m1(periodic_sample_mode_ff))
                                 ? 8'h00 : period_cnt_ff + 8'h01;
            end
            if (sample_now) begin
                raw_ff <= below_s2_ff;
            end
            // With the detector enabled, comparator is powered throughout continuous mode, else only in the last tick before a periodic sample
            o_detector_power <= detector_enable_ff & (continuous |
                (period_cnt_ff == period_m1(periodic_sample_mode_ff)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Noise filter

    bdc_pkg::bdc_filt_e filt_sel;
    logic [4:0] filt_cnt_ff;
    logic       accept_now;
    logic       detect_live;

    always_comb begin
        if (noise_filter_enable_ff & ~i_slow_osc_is_sysclk & continuous & ~i_power_down) begin
            filt_sel = bdc_pkg::FILT_FAST;
        end else if (noise_filter_enable_ff | i_power_down) begin
            filt_sel = bdc_pkg::FILT_SLOW;
        end else begin
            filt_sel = bdc_pkg::FILT_NONE;
        end
    end

    assign detect_live = detector_enable_ff & enable_prev_ff & (blank_cnt_ff == 2'h0);

    always_comb begin
        accept_now = 1'b0;
        if (detect_live & (raw_ff != accepted_ff)) begin
            case (filt_sel)
                bdc_pkg::FILT_NONE: accept_now = 1'b1;
                bdc_pkg::FILT_FAST: accept_now = (filt_cnt_ff == 5'(bdc_pkg::FAST_FILT_CYC - 1));
                bdc_pkg::FILT_SLOW: accept_now = slow_tick &
                                     (filt_cnt_ff == 5'(bdc_pkg::SLOW_FILT_TICKS - 1));
                default:            accept_now = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            accepted_ff <= 1'b0;
            filt_cnt_ff <= 5'h00;
        end else if (i_clk_en) begin
            if (~detect_live) begin
                accepted_ff <= 1'b0;
                filt_cnt_ff <= 5'h00;
            end else if ((raw_ff == accepted_ff) | accept_now) begin
                accepted_ff <= raw_ff;
                filt_cnt_ff <= 5'h00;
            end else if ((filt_sel == bdc_pkg::FILT_FAST) |
                         ((filt_sel == bdc_pkg::FILT_SLOW) & slow_tick)) begin
                filt_cnt_ff <= filt_cnt_ff + 5'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main control register

    logic cfg_below_reset;
    assign cfg_below_reset = i_nonvolatile_config_byte[bdc_pkg::MAIN_EN_BIT] &
                             ~i_nonvolatile_config_byte[bdc_pkg::MAIN_RSTEN_BIT] & below_s2_ff;

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            detector_enable_ff      <= i_nonvolatile_config_byte[bdc_pkg::MAIN_EN_BIT];
            threshold_select_ff     <= i_nonvolatile_config_byte[bdc_pkg::MAIN_THR_HI:
                                                                 bdc_pkg::MAIN_THR_LO];
            reset_on_drop_enable_ff <= i_nonvolatile_config_byte[bdc_pkg::MAIN_RSTEN_BIT];
            event_flag_ff           <= cfg_below_reset;
        end else if (i_clk_en) begin
            if (wr_main) begin
                detector_enable_ff      <= i_pwdata[bdc_pkg::MAIN_EN_BIT];
                threshold_select_ff     <= i_pwdata[bdc_pkg::MAIN_THR_HI:bdc_pkg::MAIN_THR_LO];
                reset_on_drop_enable_ff <= i_pwdata[bdc_pkg::MAIN_RSTEN_BIT];
            end
            // A crossing wins over a software clear in the same cycle
            if (accept_now) begin
                event_flag_ff <= 1'b1;
            end else if (wr_main) begin
                event_flag_ff <= i_pwdata[bdc_pkg::MAIN_EVT_BIT];
            end
        end
    end

    // Survives every reset except power-on; set by the reset this block caused
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            if (i_power_on_reset) begin
                drop_reset_flag_ff <= 1'b0;
            end else if (o_reset_req) begin
                drop_reset_flag_ff <= 1'b1;
            end
        end else if (i_clk_en & wr_main) begin
            drop_reset_flag_ff <= i_pwdata[bdc_pkg::MAIN_RFLAG_BIT];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_reset_req   <= 1'b0;
            o_trip_select <= bdc_pkg::THR_4V4;
        end else if (i_clk_en) begin
            o_reset_req   <= detector_enable_ff & reset_on_drop_enable_ff & accepted_ff;
            o_trip_select <= threshold_select_ff[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-power control register

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            periodic_sample_mode_ff <= bdc_pkg::LP_MODE_RESET;
            if (i_power_on_reset) begin
                noise_filter_enable_ff <= bdc_pkg::FLT_RESET;
            end
        end else if (i_clk_en & wr_lp) begin
            periodic_sample_mode_ff <= i_pwdata[bdc_pkg::LP_MODE_HI:bdc_pkg::LP_MODE_LO];
            noise_filter_enable_ff  <= i_pwdata[bdc_pkg::LP_FLT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, enable and clear

    logic [1:0] irq_set;
    assign irq_set = {accept_now & ~raw_ff, accept_now & raw_ff};

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_status_ff <= bdc_pkg::IRQ_RESET;
            irq_enable_ff <= bdc_pkg::IRQ_RESET;
            o_irq         <= 1'b0;
        end else if (i_clk_en) begin
            irq_status_ff <= irq_set |
                             (irq_status_ff & ~((apb_wr & hit_clr) ? i_pwdata[1:0] : 2'h0));
            if (apb_wr & hit_en) begin
                irq_enable_ff <= i_pwdata[1:0];
            end
            o_irq <= i_global_irq_enable & event_flag_ff &
                     (|(irq_status_ff & irq_enable_ff));
        end
    end

    assign o_prdata  = prdata_ff;
    assign o_pready  = pready_ff;
    assign o_pslverr = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_enable_rise;
        i_clk_en && detector_enable_ff && !enable_prev_ff;
    endsequence

    property p_blank_after_enable;
        s_enable_rise |=> !accepted_ff [*2];
    endproperty
    a_blank_after_enable: assert property (p_blank_after_enable)
        else $error("detector output accepted during enable blanking");

    property p_status_off;
        (i_clk_en && !detector_enable_ff) |=> !accepted_ff;
    endproperty
    a_status_off: assert property (p_status_off)
        else $error("status set while detector disabled");

    property p_event_on_cross;
        (i_clk_en && accept_now) |=> event_flag_ff;
    endproperty
    a_event_on_cross: assert property (p_event_on_cross)
        else $error("crossing did not set event flag");

    property p_irq_gate;
        (i_clk_en && !(i_global_irq_enable && event_flag_ff)) |=> !o_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without flag and global enable");

    property p_reset_req;
        (i_clk_en && detector_enable_ff && reset_on_drop_enable_ff && accepted_ff)
            |=> o_reset_req;
    endproperty
    a_reset_req: assert property (p_reset_req)
        else $error("drop below threshold did not request reset");

    property p_locked_write;
        (apb_wr && hit_main && !ta_open && !accept_now)
            |=> $stable(detector_enable_ff) && $stable(threshold_select_ff)
                && $stable(event_flag_ff);
    endproperty
    a_locked_write: assert property (p_locked_write)
        else $error("control changed without unlock");

    property p_fast_filter;
        (accept_now && filt_sel == bdc_pkg::FILT_FAST) |-> filt_cnt_ff == 5'h1F;
    endproperty
    a_fast_filter: assert property (p_fast_filter)
        else $error("fast filter accepted before 32 clocks");

    property p_slow_filter;
        (accept_now && filt_sel == bdc_pkg::FILT_SLOW) |-> slow_tick && filt_cnt_ff == 5'h01;
    endproperty
    a_slow_filter: assert property (p_slow_filter)
        else $error("slow filter accepted before 2 ticks");

endmodule : bdc_brownout_ctrl

/* bdc_supply_model.sv */
`timescale 1ns/1ps
module bdc_supply_model (
    input  wire logic i_want_low,
    output logic      o_supply_below,
    output logic      o_slow_osc
);
    // Oscillator far faster than nominal so tick counts fit a short run; free-running
    initial o_slow_osc = 1'b0;
    always #117 o_slow_osc = ~o_slow_osc;
    // Comparator answers after an analog delay, unrelated to the core clock phase
    assign #13 o_supply_below = i_want_low;
endmodule : bdc_supply_model

/* bdc_brownout_ctrl_tb.sv */
`timescale 1ns/1ps
module bdc_brownout_ctrl_tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, por = 1'b1, gie = 1'b1, low = 1'b0;
    logic        sup, osc, dpwr, rreq, irq;
    logic        pd = 1'b0, ssys = 1'b0;
    logic [7:0]  cfg = 8'hB4;
    logic [1:0]  trip;
    int          err_total = 0, n_checks = 0, cnt;
    always #12.5 clk = ~clk;
    bdc_supply_model u_bdc_supply_model (.i_want_low(low), .o_supply_below(sup), .o_slow_osc(osc));
    bdc_brownout_ctrl #(.LP1_PERIOD(4), .LP2_PERIOD(8), .LP3_PERIOD(16)) u_bdc_brownout_ctrl (
        .i_core_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_nonvolatile_config_byte(cfg),
        .i_power_on_reset(por), .i_supply_below(sup), .i_slow_internal_osc(osc),
        .i_slow_osc_is_sysclk(ssys), .i_power_down(pd), .i_global_irq_enable(gie),
        .o_detector_power(dpwr), .o_trip_select(trip), .o_reset_req(rreq), .o_irq(irq));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [11:0] ad(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction : ad
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // Ready and read data are taken at the edge that ends the access cycle
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        if (n >= 50) check(1'b0, 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic prot(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, ad(bdc_pkg::IDX_UNLOCK), 32'h0000_00AA);
        apb(1'b1, ad(bdc_pkg::IDX_UNLOCK), 32'h0000_0055);
        apb(1'b1, ad(idx), {24'h0, d});
    endtask : prot
    task automatic do_reset(input logic p, input logic [7:0] c);
        @(posedge clk);
        rst <= 1'b1; por <= p; cfg <= c;
        repeat (12) @(posedge clk);
        rst <= 1'b0; por <= 1'b0;
    endtask : do_reset
    task automatic rdm(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, ad(idx), 32'h0);
        check(rd, exp);
    endtask : rdm
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(20000 * 25);
        err_total++;
        test_done();
    end
    initial begin
        do_reset(1'b1, 8'hB4);
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hB4);
        check(trip, 2'b11);
        rdm(bdc_pkg::IDX_CTRL_LP, 32'h00);
        apb(1'b1, ad(bdc_pkg::IDX_CTRL_MAIN), 32'h0);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hB4);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'hA0);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA0);
        check(trip, 2'b10);
        apb(1'b1, ad(bdc_pkg::IDX_IRQ_ENABLE), 32'h3);
        low <= 1'b1;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA9);
        rdm(bdc_pkg::IDX_IRQ_STATUS, 32'h1);
        check(irq, 1'b1);
        gie <= 1'b0;
        repeat (3) @(posedge clk);
        check(irq, 1'b0);
        gie <= 1'b1;
        // Servicing alone must leave the flag standing
        repeat (3) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA9);
        apb(1'b1, ad(bdc_pkg::IDX_IRQ_CLEAR), 32'h3);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'hA0);
        repeat (40) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA1);
        check(irq, 1'b0);
        low <= 1'b0;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA8);
        rdm(bdc_pkg::IDX_IRQ_STATUS, 32'h2);
        check(irq, 1'b1);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'h00);
        low <= 1'b1;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'h00);
        check(dpwr, 1'b0);
        low <= 1'b0;
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'hA0);
        repeat (60) @(posedge clk);
        prot(bdc_pkg::IDX_CTRL_LP, 8'h01);
        rdm(bdc_pkg::IDX_CTRL_LP, 32'h01);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'hA0);
        low <= 1'b1;
        repeat (10) @(posedge clk);
        low <= 1'b0;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA0);
        low <= 1'b1;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hA9);
        low <= 1'b0;
        prot(bdc_pkg::IDX_CTRL_LP, 8'h02);
        cnt = 0;
        repeat (100) begin
            @(negedge clk);
            cnt += int'(dpwr === 1'b1);
        end
        check(cnt > 0 && cnt < 100, 1'b1);
        prot(bdc_pkg::IDX_CTRL_LP, 8'h00);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'h84);
        repeat (60) @(posedge clk);
        low <= 1'b1;
        repeat (60) @(posedge clk);
        check(rreq, 1'b1);
        low <= 1'b0;
        do_reset(1'b0, 8'hB4);
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'hB6);
        low <= 1'b1;
        do_reset(1'b1, 8'h80);
        repeat (60) @(posedge clk);
        apb(1'b0, ad(bdc_pkg::IDX_CTRL_MAIN), 32'h0);
        check(rd & 32'h0A, 32'h08);
        apb(1'b0, 12'h000, 32'h0);
        check(err, 1'b1);
        check(rd, 32'h0);
        low <= 1'b0;
        repeat (60) @(posedge clk);
        prot(bdc_pkg::IDX_CTRL_MAIN, 8'h80);
        // Power-down filters even with the filter bit off: a short dip is ignored
        pd <= 1'b1;
        low <= 1'b1;
        repeat (5) @(posedge clk);
        low <= 1'b0;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'h80);
        pd <= 1'b0;
        ssys <= 1'b1;
        prot(bdc_pkg::IDX_CTRL_LP, 8'h01);
        // Slow system clock: two ticks suffice, far fewer than 32 clocks
        low <= 1'b1;
        repeat (25) @(posedge clk);
        low <= 1'b0;
        repeat (60) @(posedge clk);
        rdm(bdc_pkg::IDX_CTRL_MAIN, 32'h88);
        test_done();
    end
endmodule : bdc_brownout_ctrl_tb
